// >>> shared/pmsc_pkg.sv
// package: register map, field positions, reset values and carrier types for the power status block
package pmsc_pkg;

  // register map (byte addresses, one aligned word each)
  localparam logic [3:0] PMSC_OFF_CTRL2 = 4'h0;
  localparam logic [3:0] PMSC_OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] PMSC_OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] PMSC_OFF_LIVE = 4'hc;

  // power_mgmt_status_ctrl_two field positions
  localparam int PMSC_BIT_WARN_FLAG = 7;
  localparam int PMSC_BIT_WARN_ACK = 6;
  localparam int PMSC_BIT_DETECT_SEL = 5;
  localparam int PMSC_BIT_WARN_SEL = 4;
  localparam int PMSC_BIT_PPD_FLAG = 3;
  localparam int PMSC_BIT_PPD_ACK = 2;
  localparam int PMSC_BIT_STOP_SEL = 0;

  // interrupt status / mask field positions
  localparam int PMSC_IRQ_WARN = 0;
  localparam int PMSC_IRQ_PPD = 1;
  localparam int PMSC_IRQ_WIDTH = 2;

  // reset values
  localparam logic PMSC_RST_TRIP_SEL = 1'b0;
  localparam logic PMSC_RST_FLAG = 1'b0;
  localparam logic PMSC_RST_STOP_SEL = 1'b0;
  localparam logic [1:0] PMSC_RST_IRQ = 2'h0;

  // axi response codes
  localparam logic [1:0] PMSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMSC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } pmsc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmsc_axi_rsp_t;

  // one decoded register write, presented for a single cycle
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [7:0] data;
    logic lane0;
  } pmsc_wr_t;

endpackage

// >>> hdl/pmsc_axi_slave.sv
// axi4-lite slave front end: accepts one write and one read, hands them to the register core
`timescale 1ns/100ps
`default_nettype none
module pmsc_axi_slave
  import pmsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pmsc_axi_req_t axi_req_in,
  output pmsc_axi_rsp_t axi_rsp_out,
  output pmsc_wr_t wr_out,
  output logic rd_strobe_out,
  output logic [3:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_hit_in,
  input wire logic wr_hit_in
);

  typedef struct packed {
    logic aw_held;
    logic [3:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rd_pend;
    logic [3:0] araddr;
  } pmsc_axs_state_t;

  pmsc_axs_state_t st_ff;
  pmsc_axs_state_t nxt_st;
  logic do_write;

  always_comb begin
    nxt_st = st_ff;
    wr_out = '0;
    rd_strobe_out = 1'b0;
    rd_addr_out = st_ff.araddr;
    do_write = 1'b0;
    // address and data may arrive in either order; hold each until both are here
    if (axi_req_in.awvalid && !st_ff.aw_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = axi_req_in.wdata;
      nxt_st.wstrb = axi_req_in.wstrb;
    end
    if (st_ff.aw_held && st_ff.w_held) begin
      do_write = 1'b1;
      wr_out.valid = 1'b1;
      wr_out.addr = st_ff.awaddr;
      wr_out.data = st_ff.wdata[7:0];
      wr_out.lane0 = st_ff.wstrb[0];
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_hit_in ? PMSC_RESP_OKAY : PMSC_RESP_SLVERR;
    end
    if (st_ff.bvalid && axi_req_in.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read: take address, sample data one cycle later
    if (axi_req_in.arvalid && !st_ff.rd_pend && !st_ff.rvalid) begin
      nxt_st.rd_pend = 1'b1;
      nxt_st.araddr = axi_req_in.araddr;
    end
    if (st_ff.rd_pend) begin
      rd_strobe_out = 1'b1;
      nxt_st.rd_pend = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_hit_in ? rd_data_in : 32'h0000_0000;
      nxt_st.rresp = rd_hit_in ? PMSC_RESP_OKAY : PMSC_RESP_SLVERR;
    end
    if (st_ff.rvalid && axi_req_in.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (do_write) begin
      nxt_st.wdata = st_ff.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    axi_rsp_out.awready = !st_ff.aw_held && !st_ff.bvalid;
    axi_rsp_out.wready = !st_ff.w_held && !st_ff.bvalid;
    axi_rsp_out.bvalid = st_ff.bvalid;
    axi_rsp_out.bresp = st_ff.bresp;
    axi_rsp_out.arready = !st_ff.rd_pend && !st_ff.rvalid;
    axi_rsp_out.rvalid = st_ff.rvalid;
    axi_rsp_out.rdata = st_ff.rdata;
    axi_rsp_out.rresp = st_ff.rresp;
  end

endmodule
`default_nettype wire

// >>> hdl/pmsc_top.sv
// power management status and control register block with axi4-lite access and interrupt
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pmsc_top
  import pmsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic undervolt_warning_in,
  input wire logic ppd_wake_in,
  input wire pmsc_axi_req_t axi_req_in,
  output pmsc_axi_rsp_t axi_rsp_out,
  output logic detect_trip_select_out,
  output logic warning_trip_select_out,
  output logic stop_variant_select_out,
  output logic irq_out
);

  // por_in: qualifies reset_in as a power-on reset (async source, synchronised)
  // undervolt_warning_in, ppd_wake_in: analog/power domain levels, synchronised

  typedef struct packed {
    logic [1:0] warn_sync;
    logic [1:0] ppd_sync;
    logic [1:0] por_sync;
    logic ppd_wake_prev;
    logic undervolt_warning_flag;
    logic detect_trip_select;
    logic warning_trip_select;
    logic partial_powerdown_flag;
    logic stop_variant_select;
    logic stop_sel_locked;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
  } pmsc_state_t;

  pmsc_state_t st_ff;
  pmsc_state_t nxt_st;
  pmsc_wr_t wr;
  logic rd_strobe;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic warn_live;
  logic ppd_rise;
  logic [1:0] irq_events;

  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == PMSC_OFF_CTRL2) || (addr == PMSC_OFF_IRQ_STATUS) ||
                (addr == PMSC_OFF_IRQ_MASK) || (addr == PMSC_OFF_LIVE);
  endfunction

  function automatic logic [7:0] ctrl2_image(input pmsc_state_t s);
    ctrl2_image = 8'h00;
    ctrl2_image[PMSC_BIT_WARN_FLAG] = s.undervolt_warning_flag;
    ctrl2_image[PMSC_BIT_DETECT_SEL] = s.detect_trip_select;
    ctrl2_image[PMSC_BIT_WARN_SEL] = s.warning_trip_select;
    ctrl2_image[PMSC_BIT_PPD_FLAG] = s.partial_powerdown_flag;
    ctrl2_image[PMSC_BIT_STOP_SEL] = s.stop_variant_select;
    // ack bits stay zero in the image
    ctrl2_image[PMSC_BIT_WARN_ACK] = 1'b0;
    ctrl2_image[PMSC_BIT_PPD_ACK] = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  pmsc_axi_slave pmsc_axi_slave_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .axi_req_in(axi_req_in),
    .axi_rsp_out(axi_rsp_out),
    .wr_out(wr),
    .rd_strobe_out(rd_strobe),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_hit_in(rd_hit),
    .wr_hit_in(wr_hit)
  );

  assign wr_hit = is_mapped(wr.addr) && (wr.addr != PMSC_OFF_LIVE);
  assign rd_hit = is_mapped(rd_addr);

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      PMSC_OFF_CTRL2: begin
        rd_data[7:0] = ctrl2_image(st_ff);
      end
      PMSC_OFF_IRQ_STATUS: begin
        rd_data[PMSC_IRQ_WIDTH-1:0] = st_ff.irq_status;
      end
      PMSC_OFF_IRQ_MASK: begin
        rd_data[PMSC_IRQ_WIDTH-1:0] = st_ff.irq_mask;
      end
      PMSC_OFF_LIVE: begin
        rd_data[PMSC_IRQ_WARN] = st_ff.warn_sync[1];
        rd_data[PMSC_IRQ_PPD] = st_ff.ppd_sync[1];
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    warn_live = st_ff.warn_sync[1];
    ppd_rise = st_ff.ppd_sync[1] && !st_ff.ppd_wake_prev;
    irq_events = 2'h0;

    nxt_st.warn_sync = {st_ff.warn_sync[0], undervolt_warning_in};
    nxt_st.ppd_sync = {st_ff.ppd_sync[0], ppd_wake_in};
    nxt_st.por_sync = {st_ff.por_sync[0], por_in};
    nxt_st.ppd_wake_prev = st_ff.ppd_sync[1];

    // register writes; lane 0 carries the whole 8-bit register
    if (wr.valid && wr.lane0) begin
      unique case (wr.addr)
        PMSC_OFF_CTRL2: begin
          if (wr.data[PMSC_BIT_WARN_ACK] && !warn_live) begin
            nxt_st.undervolt_warning_flag = 1'b0;
          end
          if (wr.data[PMSC_BIT_PPD_ACK]) begin
            nxt_st.partial_powerdown_flag = 1'b0;
          end
          nxt_st.detect_trip_select = wr.data[PMSC_BIT_DETECT_SEL];
          nxt_st.warning_trip_select = wr.data[PMSC_BIT_WARN_SEL];
          // write-once: any write locks the bit, whatever value it carries
          if (!st_ff.stop_sel_locked) begin
            nxt_st.stop_variant_select = wr.data[PMSC_BIT_STOP_SEL];
            nxt_st.stop_sel_locked = 1'b1;
          end
        end
        PMSC_OFF_IRQ_STATUS: begin
          nxt_st.irq_status = st_ff.irq_status & ~wr.data[PMSC_IRQ_WIDTH-1:0];
        end
        PMSC_OFF_IRQ_MASK: begin
          nxt_st.irq_mask = wr.data[PMSC_IRQ_WIDTH-1:0];
        end
        default: begin
          nxt_st.irq_mask = st_ff.irq_mask;
        end
      endcase
    end

    // hardware sets win over a same-cycle software clear
    if (warn_live) begin
      nxt_st.undervolt_warning_flag = 1'b1;
      if (!st_ff.undervolt_warning_flag) begin
        irq_events[PMSC_IRQ_WARN] = 1'b1;
      end
    end
    if (ppd_rise) begin
      nxt_st.partial_powerdown_flag = 1'b1;
      irq_events[PMSC_IRQ_PPD] = 1'b1;
    end
    nxt_st.irq_status = nxt_st.irq_status | irq_events;
    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // por_sync is sampled by the reset branch; it was caught by the clock before reset release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff.warn_sync <= nxt_st.warn_sync;
      st_ff.ppd_sync <= nxt_st.ppd_sync;
      st_ff.por_sync <= nxt_st.por_sync;
      st_ff.ppd_wake_prev <= 1'b0;
      // flag cleared here, re-set by the comparator right after release if still low
      st_ff.undervolt_warning_flag <= PMSC_RST_FLAG;
      st_ff.partial_powerdown_flag <= PMSC_RST_FLAG;
      st_ff.stop_variant_select <= PMSC_RST_STOP_SEL;
      st_ff.stop_sel_locked <= 1'b0;
      st_ff.irq_status <= PMSC_RST_IRQ;
      st_ff.irq_mask <= PMSC_RST_IRQ;
      st_ff.irq <= 1'b0;
      if (st_ff.por_sync[1]) begin
        st_ff.detect_trip_select <= PMSC_RST_TRIP_SEL;
        st_ff.warning_trip_select <= PMSC_RST_TRIP_SEL;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    detect_trip_select_out = st_ff.detect_trip_select;
    warning_trip_select_out = st_ff.warning_trip_select;
    stop_variant_select_out = st_ff.stop_variant_select;
    irq_out = st_ff.irq;
  end

endmodule
`default_nettype wire

// >>> tb/pmsc_checker.sv
// port-level assertions for the power status block
`timescale 1ns/100ps
`default_nettype none
module pmsc_checker
  import pmsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic undervolt_warning_in,
  input wire logic ppd_wake_in,
  input wire pmsc_axi_req_t axi_req_in,
  input wire pmsc_axi_rsp_t axi_rsp_out,
  input wire logic detect_trip_select_out,
  input wire logic warning_trip_select_out,
  input wire logic stop_variant_select_out,
  input wire logic irq_out
);
  logic [1:0] stop_moves_ff;
  default clocking cb @(posedge clk_in);
  endclocking
  ////////////////////////////////////////
  // saturating count of stop select moves since reset; a second move means the lock failed
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stop_moves_ff <= 2'h0;
    end else if ($changed(stop_variant_select_out) && stop_moves_ff != 2'h3) begin
      stop_moves_ff <= stop_moves_ff + 2'h1;
    end
  end
  a_stop_write_once: assert property (disable iff (reset_in) stop_moves_ff <= 2'h1)
    else $error("stop select moved twice");
  a_reset_stop_clr: assert property (reset_in |=> !stop_variant_select_out && !irq_out)
    else $error("stop select or irq not cleared by reset");
  // por is synchronised, so only a reset with por held for several cycles must clear trips
  a_por_trip_clr: assert property ((reset_in && por_in)[*4] |=> !detect_trip_select_out && !warning_trip_select_out)
    else $error("trip selects kept over power-on reset");
  a_other_trip_keep: assert property ((reset_in && !por_in)[*4] |=>
    $stable(detect_trip_select_out) && $stable(warning_trip_select_out))
    else $error("trip selects changed by other reset");
  a_read_latency: assert property (disable iff (reset_in)
    axi_req_in.arvalid && axi_rsp_out.arready |-> ##2 axi_rsp_out.rvalid)
    else $error("read answer late");
  a_write_latency: assert property (disable iff (reset_in) axi_req_in.awvalid && axi_rsp_out.awready &&
    axi_req_in.wvalid && axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid)
    else $error("write answer late");
  a_rdata_upper_zero: assert property (disable iff (reset_in) axi_rsp_out.rvalid |-> axi_rsp_out.rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_busy_refuse: assert property (disable iff (reset_in) axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready)
    else $error("write accepted while response pending");
  c_slverr: cover property (axi_rsp_out.bvalid && axi_rsp_out.bresp == PMSC_RESP_SLVERR);
  c_irq: cover property ($rose(irq_out));
  c_stop: cover property ($rose(stop_variant_select_out));
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// register-level testbench for the power status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench
  import pmsc_pkg::*;
;
  localparam logic [3:0] C2 = PMSC_OFF_CTRL2;
  localparam logic [3:0] ST = PMSC_OFF_IRQ_STATUS;
  localparam logic [3:0] MK = PMSC_OFF_IRQ_MASK;
  localparam logic [1:0] OK = PMSC_RESP_OKAY;
  localparam logic [1:0] ER = PMSC_RESP_SLVERR;
  logic clk_in, reset_in, por_in, uv, wake, det, wsel, stop, irq;
  pmsc_axi_req_t req;
  pmsc_axi_rsp_t rsp;
  int errors, samples_checked;
  pmsc_top pmsc_top_inst (.clk_in(clk_in), .reset_in(reset_in), .por_in(por_in), .undervolt_warning_in(uv),
    .ppd_wake_in(wake), .axi_req_in(req), .axi_rsp_out(rsp), .detect_trip_select_out(det),
    .warning_trip_select_out(wsel), .stop_variant_select_out(stop), .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] e);
    int n;
    n = 0;
    req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:{24'h0, v}, wstrb:4'hf, bready:1'b1, default:'0};
    do begin
      @(posedge clk_in);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    // a write that never answers must not pass on a default response code
    `CHK("bvalid", 1'b1, rsp.bvalid)
    `CHK("bresp", e, rsp.bresp)
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] e);
    int n;
    n = 0;
    req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
    do begin
      @(posedge clk_in);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    `CHK("rvalid", 1'b1, rsp.rvalid)
    `CHK("rdata", x, rsp.rdata)
    `CHK("rresp", e, rsp.rresp)
    req <= '0;
    @(posedge clk_in);
  endtask
  // por is driven to p with reset and dropped one edge after release, well clear of the sync delay
  task automatic rst(input logic p);
    por_in <= p;
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    por_in <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    errors = 0;
    samples_checked = 0;
    uv = 1'b0;
    wake = 1'b0;
    req = '0;
    reset_in = 1'b1;
    por_in = 1'b1;
    rst(1'b1);
    rd(C2, 32'h0, OK);
    wr(C2, 8'h31, OK);
    rd(C2, 32'h31, OK);
    `CHK("det", 1'b1, det)
    `CHK("wsel", 1'b1, wsel)
    wr(C2, 8'h44, OK);
    rd(C2, 32'h01, OK);
    `CHK("stop", 1'b1, stop)
    `CHK("wsel", 1'b0, wsel)
    uv <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(C2, 32'h81, OK);
    `CHK("irq", 1'b0, irq)
    wr(MK, 8'h03, OK);
    `CHK("irq", 1'b1, irq)
    wr(C2, 8'h41, OK);
    rd(C2, 32'h81, OK);
    uv <= 1'b0;
    repeat (5) @(posedge clk_in);
    rd(C2, 32'h81, OK);
    wr(C2, 8'h41, OK);
    rd(C2, 32'h01, OK);
    wr(ST, 8'h01, OK);
    `CHK("irq", 1'b0, irq)
    wake <= 1'b1;
    repeat (4) @(posedge clk_in);
    wake <= 1'b0;
    rd(C2, 32'h09, OK);
    rd(ST, 32'h02, OK);
    `CHK("irq", 1'b1, irq)
    wr(C2, 8'h04, OK);
    rd(C2, 32'h01, OK);
    wr(ST, 8'h02, OK);
    `CHK("irq", 1'b0, irq)
    wr(PMSC_OFF_LIVE, 8'hff, ER);
    wr(4'h2, 8'hff, ER);
    rd(4'h2, 32'h0, ER);
    wr(C2, 8'h30, OK);
    rst(1'b0);
    rd(C2, 32'h30, OK);
    `CHK("stop", 1'b0, stop)
    wr(C2, 8'h31, OK);
    rd(C2, 32'h31, OK);
    uv <= 1'b1;
    rst(1'b1);
    repeat (5) @(posedge clk_in);
    rd(C2, 32'h80, OK);
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    errors++;
    tally_and_finish;
  end
endmodule
bind pmsc_top pmsc_checker pmsc_checker_inst (.clk_in(clk_in), .reset_in(reset_in), .por_in(por_in),
  .undervolt_warning_in(undervolt_warning_in), .ppd_wake_in(ppd_wake_in), .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out), .detect_trip_select_out(detect_trip_select_out),
  .warning_trip_select_out(warning_trip_select_out), .stop_variant_select_out(stop_variant_select_out),
  .irq_out(irq_out));
`default_nettype wire
